// [psave_defs.vh]
// Purpose : offsets, field positions, reset values for the power-save bank
// Assumes : byte addresses on an 8-bit register port, 8-bit data
// Notes   : definitions only
//
// Summary of operation
// - global bit 0 puts all seven function blocks saving
// - global bit 1 lets per-function bits decide
// - thermal shutdown and 5V regulator always powered
// - global 0 ignores all per-function bits
// - function bits map 7,5..0; bit 6 zero
// - function bit 1 keeps block powered
// - identity register read-only, writes ignored
// - raw alarm monitor read-only, bits 7,1,0 one
// - regulator trim read/write, resets zero
// - current amp trim read/write, resets zero
// - reference temp trim read/write, reset undefined
// - buffer amp trim read/write, reset undefined
`ifndef PSAVE_DEFS_VH
`define PSAVE_DEFS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_GLOBAL_PS   8'h02
`define OFS_FUNC_PS     8'h04
`define OFS_VREG_TRIM   8'h40
`define OFS_CURRENT_AMP_TRIM  8'h42
`define OFS_ALARM_RAW   8'h58
`define OFS_PIN_MON     8'h5c
`define OFS_IDENTITY    8'h5e
`define OFS_TRIM_GUARD  8'h60
`define OFS_TRIM_VALID  8'h74
`define OFS_REF_TRIM    8'h78
`define OFS_BUF_TRIM    8'h7a
`define OFS_IRQ_STATUS  8'h80
`define OFS_IRQ_MASK    8'h82

// ----------------------------------------
// field positions and masks
// ----------------------------------------
`define FN_PREDRV       7
`define FN_BEMF         5
`define FN_CSAMP        4
`define FN_SUPPLY       3
`define FN_HALL         2
`define FN_PUMP_REG     1
`define FN_CPUMP        0
`define FUNC_PS_MASK    8'hbf
`define GLOBAL_PS_MASK  8'h01
`define TRIM_VALID_MASK 8'h01
`define ALARM_FIXED     8'h83
`define IRQ_MASK_BITS   8'h3f
`define IRQ_VIOL_BIT    5

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_ZERO        8'h00
`define RST_ALARM       8'hff
`define RST_IDENTITY    8'h3c

`endif

// [predriver_power_save_regs.v]
// Purpose : power-save control and upper register map of a motor predriver
// Assumes : one clock SYS_CLK at 125 MHz, asynchronous active-low RST_B
// Notes   : read data appear the cycle after the read strobe, only there
`timescale 1ns/1ps
`include "psave_defs.vh"

module predriver_power_save_regs #(
  parameter [7:0] IDENTITY_CODE = `RST_IDENTITY, // arbitrary value
  parameter [7:0] REF_TRIM_INIT = `RST_ZERO,
  parameter [7:0] BUF_TRIM_INIT = `RST_ZERO
) (
  // clock and reset
  input  wire       SYS_CLK,
  input  wire       RST_B,
  // register port
  input  wire [7:0] ADDR,
  input  wire [7:0] WDATA,
  input  wire       WR,
  input  wire       RD,
  output reg  [7:0] RDATA,
  // state of the lower register map
  input  wire       MOTOR_DRIVE_ENABLE,
  // raw alarm comparators, active low, bits 6..2
  input  wire [4:0] ALARM_RAW_N,
  // input pin group
  input  wire [7:0] INPUT_PINS,
  // power enables, high keeps the block powered
  output reg        CHIP_SAVE_OVERRIDE_N,
  output reg        PWR_PREDRIVER,
  output reg        PWR_BACK_EMF,
  output reg        PWR_CURRENT_AMP,
  output reg        PWR_SUPPLY_DETECT,
  output reg        PWR_HALL_INPUT,
  output reg        PWR_PUMP_REGULATOR,
  output reg        PWR_CHARGE_PUMP,
  output reg        PWR_THERMAL_SHUTDOWN,
  output reg        PWR_REGULATOR_5V,
  // trim values to the analog side
  output reg  [7:0] REGULATOR_VOLTAGE_TRIM,
  output reg  [7:0] CURRENT_AMP_TRIM,
  output reg  [7:0] REFERENCE_TEMP_TRIM,
  output reg  [7:0] BUFFER_AMP_TRIM,
  output reg  [7:0] TRIM_WRITE_GUARD,
  output reg        TRIM_VALUES_VALID,
  // interrupt
  output reg        IRQ
);

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  wire wr_global    = WR & hit(ADDR, `OFS_GLOBAL_PS);
  wire wr_func      = WR & hit(ADDR, `OFS_FUNC_PS);
  wire wr_vreg      = WR & hit(ADDR, `OFS_VREG_TRIM);
  wire wr_csamp     = WR & hit(ADDR, `OFS_CURRENT_AMP_TRIM);
  wire wr_guard     = WR & hit(ADDR, `OFS_TRIM_GUARD);
  wire wr_valid     = WR & hit(ADDR, `OFS_TRIM_VALID);
  wire wr_ref       = WR & hit(ADDR, `OFS_REF_TRIM);
  wire wr_buf       = WR & hit(ADDR, `OFS_BUF_TRIM);
  wire wr_irq_stat  = WR & hit(ADDR, `OFS_IRQ_STATUS);
  wire wr_irq_mask  = WR & hit(ADDR, `OFS_IRQ_MASK);

  // ----------------------------------------
  // stored registers
  // ----------------------------------------
  reg [7:0] global_ps_q;
  reg [7:0] func_ps_q;
  reg [7:0] vreg_trim_q;
  reg [7:0] current_amp_trim_q;
  reg [7:0] guard_q;
  reg [7:0] valid_q;
  reg [7:0] ref_trim_q;
  reg [7:0] buf_trim_q;

  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      global_ps_q  <= `RST_ZERO;
      func_ps_q    <= `RST_ZERO;
      vreg_trim_q  <= `RST_ZERO;
      current_amp_trim_q <= `RST_ZERO;
      guard_q      <= `RST_ZERO;
      valid_q      <= `RST_ZERO;
      // value is undefined to software; parameters pick the silicon value
      ref_trim_q   <= REF_TRIM_INIT;
      buf_trim_q   <= BUF_TRIM_INIT;
    end else begin
      // the motor-drive interlock is software's duty; writes still land
      if (wr_global) begin
        global_ps_q <= WDATA & `GLOBAL_PS_MASK;
      end
      if (wr_func) begin
        func_ps_q <= WDATA & `FUNC_PS_MASK;
      end
      if (wr_vreg) begin
        vreg_trim_q <= WDATA;
      end
      if (wr_csamp) begin
        current_amp_trim_q <= WDATA;
      end
      if (wr_guard) begin
        guard_q <= WDATA;
      end
      if (wr_valid) begin
        valid_q <= WDATA & `TRIM_VALID_MASK;
      end
      if (wr_ref) begin
        ref_trim_q <= WDATA;
      end
      if (wr_buf) begin
        buf_trim_q <= WDATA;
      end
    end
  end

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // three stages; a change counts once stages two and three agree
  reg [4:0] alarm_s1_q;
  reg [4:0] alarm_s2_q;
  reg [4:0] alarm_s3_q;
  reg [4:0] alarm_q;
  reg [7:0] pin_s1_q;
  reg [7:0] pin_s2_q;
  reg [7:0] pin_s3_q;
  reg [7:0] pin_q;

  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      alarm_s1_q <= 5'h1f;
      alarm_s2_q <= 5'h1f;
      alarm_s3_q <= 5'h1f;
      alarm_q    <= 5'h1f;
      pin_s1_q   <= 8'h00;
      pin_s2_q   <= 8'h00;
      pin_s3_q   <= 8'h00;
      pin_q      <= 8'h00;
    end else begin
      alarm_s1_q <= ALARM_RAW_N;
      alarm_s2_q <= alarm_s1_q;
      alarm_s3_q <= alarm_s2_q;
      alarm_q    <= (alarm_s2_q & alarm_s3_q) |
                    (alarm_q & (alarm_s2_q ^ alarm_s3_q));
      pin_s1_q   <= INPUT_PINS;
      pin_s2_q   <= pin_s1_q;
      pin_s3_q   <= pin_s2_q;
      pin_q      <= (pin_s2_q & pin_s3_q) |
                    (pin_q & (pin_s2_q ^ pin_s3_q));
    end
  end

  // monitor is unlatched: fixed ones at 7,1,0, live alarm bits 6..2
  wire [7:0] alarm_view = {1'b1, alarm_q, 2'b11};

  // ----------------------------------------
  // interrupt events
  // ----------------------------------------
  reg  [4:0] alarm_prev_q;
  reg  [7:0] irq_stat_q;
  reg  [7:0] irq_mask_q;
  wire [4:0] alarm_fall  = alarm_prev_q & ~alarm_q;
  // power-save change during drive is flagged, not blocked
  wire       ps_violate  = (wr_global | wr_func) & MOTOR_DRIVE_ENABLE;
  wire [7:0] irq_events  = {2'b00, ps_violate, alarm_fall};

  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      alarm_prev_q <= 5'h1f;
      irq_stat_q   <= `RST_ZERO;
      irq_mask_q   <= `RST_ZERO;
    end else begin
      alarm_prev_q <= alarm_q;
      // new event wins over a same-cycle clear
      if (wr_irq_stat) begin
        irq_stat_q <= (irq_stat_q & ~WDATA) | irq_events;
      end else begin
        irq_stat_q <= irq_stat_q | irq_events;
      end
      if (wr_irq_mask) begin
        irq_mask_q <= WDATA & `IRQ_MASK_BITS;
      end
    end
  end

  // ----------------------------------------
  // power-save resolution
  // ----------------------------------------
  wire       chip_on = global_ps_q[0];
  // global 0 forces every function into saving, function bits ignored
  wire [7:0] fn_on   = chip_on ? func_ps_q : 8'h00;

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  reg [7:0] rd_mux;

  always @* begin
    case (ADDR)
      `OFS_GLOBAL_PS:  rd_mux = global_ps_q;
      `OFS_FUNC_PS:    rd_mux = func_ps_q;
      `OFS_VREG_TRIM:  rd_mux = vreg_trim_q;
      `OFS_CURRENT_AMP_TRIM: rd_mux = current_amp_trim_q;
      `OFS_ALARM_RAW:  rd_mux = alarm_view;
      `OFS_PIN_MON:    rd_mux = pin_q;
      `OFS_IDENTITY:   rd_mux = IDENTITY_CODE;
      `OFS_TRIM_GUARD: rd_mux = guard_q;
      `OFS_TRIM_VALID: rd_mux = valid_q;
      `OFS_REF_TRIM:   rd_mux = ref_trim_q;
      `OFS_BUF_TRIM:   rd_mux = buf_trim_q;
      `OFS_IRQ_STATUS: rd_mux = irq_stat_q;
      `OFS_IRQ_MASK:   rd_mux = irq_mask_q;
      default:         rd_mux = 8'h00;
    endcase
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      RDATA                  <= 8'h00;
      CHIP_SAVE_OVERRIDE_N   <= 1'b0;
      PWR_PREDRIVER          <= 1'b0;
      PWR_BACK_EMF           <= 1'b0;
      PWR_CURRENT_AMP        <= 1'b0;
      PWR_SUPPLY_DETECT      <= 1'b0;
      PWR_HALL_INPUT         <= 1'b0;
      PWR_PUMP_REGULATOR     <= 1'b0;
      PWR_CHARGE_PUMP        <= 1'b0;
      PWR_THERMAL_SHUTDOWN   <= 1'b1;
      PWR_REGULATOR_5V       <= 1'b1;
      REGULATOR_VOLTAGE_TRIM <= `RST_ZERO;
      CURRENT_AMP_TRIM       <= `RST_ZERO;
      REFERENCE_TEMP_TRIM    <= REF_TRIM_INIT;
      BUFFER_AMP_TRIM        <= BUF_TRIM_INIT;
      TRIM_WRITE_GUARD       <= `RST_ZERO;
      TRIM_VALUES_VALID      <= 1'b0;
      IRQ                    <= 1'b0;
    end else begin
      // identity and monitors have no write path at all
      RDATA                  <= RD ? rd_mux : 8'h00;
      CHIP_SAVE_OVERRIDE_N   <= chip_on;
      PWR_PREDRIVER          <= fn_on[`FN_PREDRV];
      PWR_BACK_EMF           <= fn_on[`FN_BEMF];
      PWR_CURRENT_AMP        <= fn_on[`FN_CSAMP];
      PWR_SUPPLY_DETECT      <= fn_on[`FN_SUPPLY];
      PWR_HALL_INPUT         <= fn_on[`FN_HALL];
      PWR_PUMP_REGULATOR     <= fn_on[`FN_PUMP_REG];
      PWR_CHARGE_PUMP        <= fn_on[`FN_CPUMP];
      // never gated, whatever the save registers hold
      PWR_THERMAL_SHUTDOWN   <= 1'b1;
      PWR_REGULATOR_5V       <= 1'b1;
      REGULATOR_VOLTAGE_TRIM <= vreg_trim_q;
      CURRENT_AMP_TRIM       <= current_amp_trim_q;
      REFERENCE_TEMP_TRIM    <= ref_trim_q;
      BUFFER_AMP_TRIM        <= buf_trim_q;
      TRIM_WRITE_GUARD       <= guard_q;
      TRIM_VALUES_VALID      <= valid_q[0];
      IRQ                    <= |(irq_stat_q & irq_mask_q);
    end
  end

endmodule

// [predriver_power_save_regs_asserts.sv]
// Purpose : concurrent checks on the power-save bank ports
// Assumes : one clock, asynchronous active-low reset
// Notes   : bound from the testbench top file
`timescale 1ns/1ps
`include "psave_defs.vh"

module predriver_power_save_regs_asserts #(
  parameter [7:0] IDENTITY_CODE = `RST_IDENTITY
) (
  // clock and reset
  input wire       SYS_CLK,
  input wire       RST_B,
  // register port
  input wire [7:0] ADDR,
  input wire [7:0] WDATA,
  input wire       WR,
  input wire       RD,
  input wire [7:0] RDATA,
  // power enables
  input wire       CHIP_SAVE_OVERRIDE_N,
  input wire       PWR_PREDRIVER,
  input wire       PWR_BACK_EMF,
  input wire       PWR_CHARGE_PUMP,
  input wire       PWR_THERMAL_SHUTDOWN,
  input wire       PWR_REGULATOR_5V
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_B);
  // ----------------------------------------
  // write sequences
  // ----------------------------------------
  sequence func_write;
    WR && ADDR == `OFS_FUNC_PS;
  endsequence
  sequence global_write;
    WR && ADDR == `OFS_GLOBAL_PS;
  endsequence
  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_save_forces_off: assert property (!CHIP_SAVE_OVERRIDE_N |->
    !(PWR_PREDRIVER || PWR_BACK_EMF || PWR_CHARGE_PUMP)) else $error("block powered in chip save");
  chk_always_on: assert property (PWR_THERMAL_SHUTDOWN && PWR_REGULATOR_5V)
    else $error("always-on block lost power");
  chk_global_follow: assert property (global_write |=> ##1
    CHIP_SAVE_OVERRIDE_N == $past(WDATA[0], 2)) else $error("global save bit not applied");
  chk_func_follow: assert property (func_write ##1 CHIP_SAVE_OVERRIDE_N |=>
    PWR_PREDRIVER == $past(WDATA[7], 2) && PWR_BACK_EMF == $past(WDATA[5], 2)
    && PWR_CHARGE_PUMP == $past(WDATA[0], 2)) else $error("function enables wrong");
  chk_read_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data outside answer cycle");
  chk_identity_read: assert property (RD && ADDR == `OFS_IDENTITY |=>
    RDATA == IDENTITY_CODE) else $error("identity value wrong");
  chk_alarm_fixed: assert property (RD && ADDR == `OFS_ALARM_RAW |=>
    (RDATA & `ALARM_FIXED) == `ALARM_FIXED) else $error("alarm fixed bits wrong");
  chk_func_bit6: assert property (RD && ADDR == `OFS_FUNC_PS |=> !RDATA[6])
    else $error("function bit 6 not zero");
  chk_reserved_zero: assert property (RD && (ADDR == 8'h5a || ADDR == 8'h76) |=>
    RDATA == 8'h00) else $error("reserved address not zero");
endmodule

// [predriver_power_save_regs_test.sv]
// Purpose : register-level test of the power-save bank
// Assumes : register port answers one cycle after the read strobe
// Notes   : checker is bound below the module
`timescale 1ns/1ps
`include "psave_defs.vh"

module predriver_power_save_regs_test;
  localparam [7:0] ID = 8'h3c; // arbitrary value
  reg        sys_clk = 1'b0;
  reg        rst_b = 1'b0;
  reg  [7:0] addr = 8'h00;
  reg  [7:0] wdata = 8'h00;
  reg        wr_stb = 1'b0;
  reg        rd_stb = 1'b0;
  reg        motor = 1'b0;
  reg  [4:0] alarm_n = 5'h1f;
  reg  [7:0] pins = 8'h00;
  wire [7:0] rdata, vt, ct, rt, bt, gt;
  wire [6:0] pwr;
  wire       chip_n, thermal_shutdown, r5, tv, irq;
  integer    bad_count = 0;
  integer    n_checks = 0;
  integer    i;
  reg  [7:0] ra [0:9] = '{8'h02, 8'h04, 8'h40, 8'h42, 8'h58, 8'h5a, 8'h60, 8'h74, 8'h80, 8'h82};
  reg  [7:0] rv [0:9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  reg  [7:0] wa [0:9] = '{8'h02, 8'h04, 8'h40, 8'h42, 8'h78, 8'h7a, 8'h5e, 8'h58, 8'h74, 8'h5a};
  reg  [7:0] wd [0:9] = '{8'hff, 8'hff, 8'ha5, 8'h5a, 8'hc3, 8'h3c, 8'h00, 8'h00, 8'hff, 8'hff};
  reg  [7:0] we [0:9] = '{8'h01, 8'hbf, 8'ha5, 8'h5a, 8'hc3, 8'h3c, ID, 8'hff, 8'h01, 8'h00};

  always #4 sys_clk = ~sys_clk;

  predriver_power_save_regs #(.IDENTITY_CODE(ID)) dut (
    .SYS_CLK(sys_clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr_stb),
    .RD(rd_stb), .RDATA(rdata), .MOTOR_DRIVE_ENABLE(motor), .ALARM_RAW_N(alarm_n),
    .INPUT_PINS(pins), .CHIP_SAVE_OVERRIDE_N(chip_n), .PWR_PREDRIVER(pwr[6]),
    .PWR_BACK_EMF(pwr[5]), .PWR_CURRENT_AMP(pwr[4]), .PWR_SUPPLY_DETECT(pwr[3]),
    .PWR_HALL_INPUT(pwr[2]), .PWR_PUMP_REGULATOR(pwr[1]), .PWR_CHARGE_PUMP(pwr[0]),
    .PWR_THERMAL_SHUTDOWN(thermal_shutdown), .PWR_REGULATOR_5V(r5), .REGULATOR_VOLTAGE_TRIM(vt),
    .CURRENT_AMP_TRIM(ct), .REFERENCE_TEMP_TRIM(rt), .BUFFER_AMP_TRIM(bt),
    .TRIM_WRITE_GUARD(gt), .TRIM_VALUES_VALID(tv), .IRQ(irq));

  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task close_out;
    if (bad_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    n_checks = n_checks + 1;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      bad_count = bad_count + 1;
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(posedge sys_clk);
    wr_stb <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
  endtask
  task rd(input [7:0] a, input [7:0] e);
    @(posedge sys_clk);
    rd_stb <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    #1 chk($sformatf("rdata %h", a), e, rdata);
  endtask
  // bounded wait: a missed level ends the run
  task wait_irq(input v);
    integer k;
    for (k = 0; k < 20 && irq !== v; k = k + 1) @(posedge sys_clk);
    #1 chk("irq", v, irq);
    if (irq !== v) close_out();
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    #100000;
    bad_count = bad_count + 1;
    close_out();
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    for (i = 0; i < 10; i = i + 1) rd(ra[i], rv[i]);
    rd(`OFS_IDENTITY, ID);
    for (i = 0; i < 10; i = i + 1) begin
      wr(wa[i], wd[i]);
      rd(wa[i], we[i]);
    end
    chk("trims", {vt, ct, rt, bt}, 32'ha55ac33c);
    chk("pwr all", {chip_n, pwr}, 8'hff);
    wr(`OFS_TRIM_GUARD, 8'h96);
    rd(`OFS_TRIM_GUARD, 8'h96);
    chk("guard valid", {gt, tv}, 9'h12d);
    wr(`OFS_FUNC_PS, 8'h15);
    repeat (2) @(posedge sys_clk);
    #1 chk("pwr some", {thermal_shutdown, r5, pwr}, 9'h195);
    wr(`OFS_FUNC_PS, 8'hff);
    wr(`OFS_GLOBAL_PS, 8'h00);
    repeat (2) @(posedge sys_clk);
    #1 chk("pwr save", {thermal_shutdown, r5, chip_n, pwr}, 10'h300);
    wr(`OFS_GLOBAL_PS, 8'h01);
    pins <= 8'ha5;
    repeat (6) @(posedge sys_clk);
    rd(`OFS_PIN_MON, 8'ha5);
    wr(`OFS_IRQ_MASK, 8'h3f);
    alarm_n <= 5'h1e;
    wait_irq(1'b1);
    rd(`OFS_ALARM_RAW, 8'hfb);
    rd(`OFS_IRQ_STATUS, 8'h01);
    wr(`OFS_IRQ_STATUS, 8'h01);
    wait_irq(1'b0);
    wr(`OFS_IRQ_MASK, 8'h00);
    motor <= 1'b1;
    wr(`OFS_FUNC_PS, 8'h7f);
    repeat (3) @(posedge sys_clk);
    #1 chk("irq masked", 1'b0, irq);
    rd(`OFS_IRQ_STATUS, 8'h20);
    wr(`OFS_IRQ_MASK, 8'h20);
    wait_irq(1'b1);
    wr(`OFS_IRQ_STATUS, 8'h20);
    wait_irq(1'b0);
    wr(`OFS_GLOBAL_PS, 8'h01);
    wait_irq(1'b1);
    rd(`OFS_IRQ_STATUS, 8'h20);
    wr(`OFS_IRQ_STATUS, 8'h20);
    wait_irq(1'b0);
    motor <= 1'b0;
    close_out();
  end
endmodule

bind predriver_power_save_regs predriver_power_save_regs_asserts #(
  .IDENTITY_CODE(IDENTITY_CODE)) u_chk (
  .SYS_CLK(SYS_CLK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .CHIP_SAVE_OVERRIDE_N(CHIP_SAVE_OVERRIDE_N), .PWR_PREDRIVER(PWR_PREDRIVER),
  .PWR_BACK_EMF(PWR_BACK_EMF), .PWR_CHARGE_PUMP(PWR_CHARGE_PUMP),
  .PWR_THERMAL_SHUTDOWN(PWR_THERMAL_SHUTDOWN), .PWR_REGULATOR_5V(PWR_REGULATOR_5V));
